// ---- src/bst_tap.v ----
// Boundary-scan TAP controller, instruction register and boundary cells
`timescale 1ns/1ps
`include "bst_map.vh"
module bst_tap #(
  parameter NPIN = 4,
  parameter [31:0] IDCODE_VAL = `BST_ID_RST,  // Arbitrary value
  parameter [31:0] USERCODE_VAL = `BST_UC_RST,
  parameter [9:0] OP_SAMPLE = `BST_OP_SAMPLE,
  parameter [9:0] OP_EXTEST = `BST_OP_EXTEST,
  parameter [9:0] OP_IDCODE = `BST_OP_IDCODE,
  parameter [9:0] OP_USERCODE = `BST_OP_USERCODE,
  parameter [9:0] OP_CLAMP = `BST_OP_CLAMP,
  parameter [9:0] OP_HIGHZ = `BST_OP_HIGHZ
) (
  // Clock and reset
  input  wire            i_clk_sys,
  input  wire            i_rst_n,
  // Test port pins
  input  wire            i_tck,
  input  wire            i_tms,
  input  wire            i_tdi,
  output reg             o_tdo,
  output reg             o_tdo_oe_n,
  // Core side of each cell, plus the pin input
  input  wire [NPIN-1:0] i_core_output_to_cell,
  input  wire [NPIN-1:0] i_core_oe_to_cell,
  input  wire [NPIN-1:0] i_pin_in,
  // Pin side of each cell
  output reg  [NPIN-1:0] o_pin_out,
  output reg  [NPIN-1:0] o_pin_oe,
  // Global output enable
  input  wire            i_global_output_enable_pin,
  input  wire            i_goe_feature,
  // Capture snapshot stream and instruction register
  output reg             o_snap_valid,
  input  wire            i_snap_ready,
  output reg  [3*NPIN-1:0] o_snap_data,
  output reg  [9:0]      o_ir
);
  localparam BLEN = 3 * NPIN;
  localparam [15:0] S_TLR = 16'h0001, S_RTI = 16'h0002, S_SDS = 16'h0004,
    S_CDR = 16'h0008, S_SHDR = 16'h0010, S_E1DR = 16'h0020, S_PDR = 16'h0040,
    S_E2DR = 16'h0080, S_UDR = 16'h0100, S_SIS = 16'h0200, S_CIR = 16'h0400,
    S_SHIR = 16'h0800, S_E1IR = 16'h1000, S_PIR = 16'h2000, S_E2IR = 16'h4000,
    S_UIR = 16'h8000;
  // Two-stage synchronisers; TCK edges are found after the second stage
  reg  [2:0]      tck_s_q;
  reg  [1:0]      tms_s_q;
  reg  [1:0]      tdi_s_q;
  reg  [NPIN-1:0] pin_s1_q;
  reg  [NPIN-1:0] pin_s2_q;
  reg  [NPIN-1:0] goe_s_q;
  reg             goe_s1_q;
  reg  [15:0]     st_q;
  reg  [15:0]     st_d;
  reg  [9:0]      ir_sh_q;
  reg  [BLEN-1:0] cap_q;
  reg  [BLEN-1:0] upd_q;
  reg  [31:0]     id_q;
  reg             byp_q;
  wire            rise;
  wire            fall;
  wire            tms;
  wire            tdi;
  wire            dec_sample;
  wire            dec_extest;
  wire            dec_id;
  wire            dec_uc;
  wire            dec_clamp;
  wire            dec_highz;
  wire            sel_bsr;
  wire            sel_id;
  wire            test_mode;
  reg             ser_out;
  reg  [BLEN-1:0] live;
  integer         k;
  assign rise = tck_s_q[1] && !tck_s_q[2];
  assign fall = !tck_s_q[1] && tck_s_q[2];
  assign tms  = tms_s_q[1];
  assign tdi  = tdi_s_q[1];
  assign dec_sample = (o_ir == OP_SAMPLE);
  assign dec_extest = (o_ir == OP_EXTEST);
  assign dec_id     = (o_ir == OP_IDCODE);
  assign dec_uc     = (o_ir == OP_USERCODE);
  assign dec_clamp  = (o_ir == OP_CLAMP);
  assign dec_highz  = (o_ir == OP_HIGHZ);
  assign sel_bsr    = dec_sample || dec_extest;
  assign sel_id     = dec_id || dec_uc;
  assign test_mode  = (dec_extest || dec_clamp || dec_highz) && (st_q != S_TLR);
  always @* begin
    st_d = S_TLR;
    case (st_q)
      S_TLR:  st_d = tms ? S_TLR : S_RTI;
      S_RTI:  st_d = tms ? S_SDS : S_RTI;
      S_SDS:  st_d = tms ? S_SIS : S_CDR;
      S_CDR:  st_d = tms ? S_E1DR : S_SHDR;
      S_SHDR: st_d = tms ? S_E1DR : S_SHDR;
      S_E1DR: st_d = tms ? S_UDR : S_PDR;
      S_PDR:  st_d = tms ? S_E2DR : S_PDR;
      S_E2DR: st_d = tms ? S_UDR : S_SHDR;
      S_UDR:  st_d = tms ? S_SDS : S_RTI;
      S_SIS:  st_d = tms ? S_TLR : S_CIR;
      S_CIR:  st_d = tms ? S_E1IR : S_SHIR;
      S_SHIR: st_d = tms ? S_E1IR : S_SHIR;
      S_E1IR: st_d = tms ? S_UIR : S_PIR;
      S_PIR:  st_d = tms ? S_E2IR : S_PIR;
      S_E2IR: st_d = tms ? S_UIR : S_SHIR;
      S_UIR:  st_d = tms ? S_SDS : S_RTI;
      default: st_d = S_TLR;
    endcase
  end
  always @* begin
    live = {BLEN{1'b0}};
    for (k = 0; k < NPIN; k = k + 1) begin
      live[3*k+`BST_CELL_OUT] = i_core_output_to_cell[k];
      live[3*k+`BST_CELL_OE]  = i_core_oe_to_cell[k];
      live[3*k+`BST_CELL_IN]  = pin_s2_q[k];
    end
  end
  always @* begin
    if (st_q == S_SHIR) begin
      ser_out = ir_sh_q[0];
    end else if (sel_bsr) begin
      ser_out = cap_q[0];
    end else if (sel_id) begin
      ser_out = id_q[0];
    end else begin
      ser_out = byp_q;
    end
  end
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tck_s_q  <= 3'h0;
      tms_s_q  <= 2'h3;
      tdi_s_q  <= 2'h3;
      pin_s1_q <= {NPIN{1'b0}};
      pin_s2_q <= {NPIN{1'b0}};
      goe_s1_q <= 1'b1;
      goe_s_q  <= {NPIN{1'b1}};
    end else begin
      tck_s_q  <= {tck_s_q[1:0], i_tck};
      tms_s_q  <= {tms_s_q[0], i_tms};
      tdi_s_q  <= {tdi_s_q[0], i_tdi};
      pin_s1_q <= i_pin_in;
      pin_s2_q <= pin_s1_q;
      goe_s1_q <= i_global_output_enable_pin;
      goe_s_q  <= {NPIN{goe_s1_q}};
    end
  end
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q    <= S_TLR;
      ir_sh_q <= `BST_OP_IDCODE;
      o_ir    <= `BST_OP_IDCODE;
      cap_q   <= {BLEN{1'b0}};
      upd_q   <= {BLEN{1'b0}};
      id_q    <= 32'h00000000;
      byp_q   <= 1'b0;
    end else if (rise) begin
      st_q <= st_d;
      // IDCODE on reset entry
      // Loaded on entry so test modes drop with the state
      if (st_d == S_TLR) begin
        o_ir <= OP_IDCODE;
      end
      case (st_q)
        S_CIR: begin
          ir_sh_q <= o_ir;
        end
        S_SHIR: begin
          ir_sh_q <= {tdi, ir_sh_q[9:1]};
        end
        S_UIR: begin
          o_ir <= ir_sh_q;
        end
        S_CDR: begin
          if (sel_bsr) begin
            cap_q <= live;
          end
          id_q  <= dec_uc ? USERCODE_VAL : IDCODE_VAL;
          byp_q <= 1'b0;
        end
        S_SHDR: begin
          if (sel_bsr) begin
            cap_q <= {tdi, cap_q[BLEN-1:1]};
          end
          id_q  <= {tdi, id_q[31:1]};
          byp_q <= tdi;
        end
        S_UDR: begin
          if (sel_bsr) begin
            upd_q <= cap_q;
          end
        end
        default: begin
          byp_q <= byp_q;
        end
      endcase
    end
  end
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tdo      <= `BST_TDO_RST;
      o_tdo_oe_n <= 1'b1;
    end else if (fall) begin
      o_tdo      <= ser_out;
      o_tdo_oe_n <= !((st_q == S_SHIR) || (st_q == S_SHDR));
    end
  end
  // Output muxes; sample keeps core path live
  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_pin
      always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
          o_pin_out[g] <= 1'b0;
          o_pin_oe[g]  <= 1'b0;
        end else if (test_mode && dec_highz) begin
          o_pin_out[g] <= 1'b0;
          o_pin_oe[g]  <= 1'b0;
        end else if (test_mode) begin
          o_pin_out[g] <= upd_q[3*g+`BST_CELL_OUT];
          o_pin_oe[g]  <= upd_q[3*g+`BST_CELL_OE];
        end else begin
          o_pin_out[g] <= i_core_output_to_cell[g];
          o_pin_oe[g]  <= i_core_oe_to_cell[g] && (goe_s_q[g] || !i_goe_feature);
        end
      end
    end
  endgenerate
  // Snapshot of each capture; drops when the stream is stalled
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_snap_valid <= 1'b0;
      o_snap_data  <= {BLEN{1'b0}};
    end else if (rise && st_q == S_CDR && sel_bsr && (i_snap_ready || !o_snap_valid)) begin
      o_snap_valid <= 1'b1;
      o_snap_data  <= live;
    end else if (i_snap_ready) begin
      o_snap_valid <= 1'b0;
    end
  end
endmodule

// ---- src/bst_map.vh ----
// Constants for the boundary-scan test logic
`ifndef BST_MAP_VH
`define BST_MAP_VH
`define BST_IR_LEN        10
`define BST_CELL_BITS     3
`define BST_CELL_OUT      0
`define BST_CELL_OE       1
`define BST_CELL_IN       2
`define BST_OP_BYPASS     10'h3FF
`define BST_OP_SAMPLE     10'h005
`define BST_OP_EXTEST     10'h00F
`define BST_OP_IDCODE     10'h006
`define BST_OP_USERCODE   10'h007
`define BST_OP_CLAMP      10'h00A
`define BST_OP_HIGHZ      10'h00B
`define BST_ID_RST        32'h12345679
`define BST_UC_RST        32'hFFFFFFFF
`define BST_TDO_RST       1'b0
`endif

// ---- src/bst_fifo.v ----
// Small valid/ready FIFO for the captured pin snapshot stream
`timescale 1ns/1ps
module bst_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             i_clk_sys,
  input  wire             i_rst_n,
  // Fill side
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  // Drain side
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;
  assign o_in_ready  = (cnt_q != DEPTH[AW:0]);
  assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
  assign o_out_data  = mem_q[rd_q];
  assign push = i_in_valid && o_in_ready;
  assign pop  = o_out_valid && i_out_ready;
  always @(posedge i_clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// ---- verification/bst_tester.sv ----
// Tester model stepping the test port one clock at a time
`timescale 1ns/1ps
module bst_tester (
  // Pacing clock
  input  wire logic i_clk_sys,
  // Test port
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  input  wire logic i_tdo,
  input  wire logic i_tdo_oe_n
);
  // Clock idles low, data lines rest at pull-up level
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end
  // set before rise, read after fall
  task step(input logic m, input logic d, output logic q);
    o_tms = m;
    o_tdi = d;
    @(negedge i_clk_sys) o_tck = 1'b1;
    repeat (4) @(negedge i_clk_sys);
    o_tck = 1'b0;
    // Low phase just long enough for the synced fall to land
    repeat (3) @(negedge i_clk_sys);
    q = i_tdo_oe_n ? 1'bz : i_tdo;
  endtask
endmodule

// ---- verification/bst_tap_chk.sv ----
// Concurrent checks on the boundary-scan TAP ports
`timescale 1ns/1ps
`include "bst_map.vh"
module bst_tap_chk #(parameter NPIN = 4) (
  // Clock, reset, test port
  input wire logic i_clk_sys, i_rst_n, i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe_n,
  // Cells and global enable
  input wire logic [NPIN-1:0] i_core_output_to_cell, i_core_oe_to_cell, i_pin_in,
  input wire logic [NPIN-1:0] o_pin_out, o_pin_oe,
  input wire logic i_global_output_enable_pin, i_goe_feature,
  // Snapshot stream and instruction
  input wire logic o_snap_valid, i_snap_ready,
  input wire logic [3*NPIN-1:0] o_snap_data,
  input wire logic [9:0] o_ir
);
  // Next state per TMS level, one nibble per state
  localparam logic [63:0] NX1 = 64'h2FEFCC0287855920;
  localparam logic [63:0] NX0 = 64'h1BDDBBA146644311;
  logic [3:0] st_q;
  logic       tck_q;
  logic [3:0] fcnt_q;
  logic       norm;
  assign norm = (st_q == 4'h0) || (o_ir == `BST_OP_SAMPLE);
  // Raw pin edges: the model leads the design by its sync delay
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= 4'h0;
      tck_q <= 1'b0;
      fcnt_q <= 4'h0;
    end else begin
      tck_q <= i_tck;
      fcnt_q <= i_tck ? 4'h0 : ((fcnt_q == 4'hF) ? fcnt_q : fcnt_q + 4'h1);
      if (i_tck && !tck_q) st_q <= i_tms ? NX1[st_q*4 +: 4] : NX0[st_q*4 +: 4];
    end
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  tdo_fall_a: assert property (($changed(o_tdo) || $changed(o_tdo_oe_n)) |->
    !i_tck && fcnt_q <= 4'h6) else $error("tdo moved away from a test clock fall");
  tdo_drive_a: assert property ($fell(i_tck) |-> ##3
    o_tdo_oe_n == !(st_q == 4'h4 || st_q == 4'hB)) else $error("tdo enable wrong");
  ir_reset_a: assert property ((st_q == 4'h0)[*5] |-> o_ir == `BST_OP_IDCODE)
    else $error("instruction not idcode in reset state");
  ir_update_a: assert property ($changed(o_ir) |-> $past(st_q, 3) == 4'hF || st_q == 4'h0)
    else $error("instruction changed outside update");
  pin_norm_a: assert property ((norm && $stable(i_core_output_to_cell))[*4] |->
    o_pin_out == i_core_output_to_cell) else $error("pin out not core value");
  oe_norm_a: assert property ((norm && !i_goe_feature)[*4] |->
    o_pin_oe == i_core_oe_to_cell) else $error("pin oe not core value");
  goe_off_a: assert property ((norm && i_goe_feature && !i_global_output_enable_pin)[*4]
    |-> o_pin_oe == '0) else $error("pins driven with global enable low");
  highz_oe_a: assert property ((o_ir == `BST_OP_HIGHZ)[*3] |-> o_pin_oe == '0)
    else $error("pins driven under highz");
  snap_hold_a: assert property (o_snap_valid && !i_snap_ready |=>
    o_snap_valid && $stable(o_snap_data)) else $error("snapshot dropped while waiting");
  cover property (st_q == 4'hB);
  cover property (o_ir == `BST_OP_EXTEST);
  cover property (o_snap_valid && !i_snap_ready);
endmodule
bind bst_tap bst_tap_chk #(.NPIN(NPIN)) i_bst_tap_chk (.*);

// ---- verification/tb_bst_tap.sv ----
// Testbench for the boundary-scan TAP block
`timescale 1ns/1ps
`include "bst_map.vh"
module tb_bst_tap;
  localparam NPIN = 2;
  logic i_clk_sys = 1'b0, i_rst_n = 1'b0, i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe_n;
  logic i_global_output_enable_pin = 1'b0, i_goe_feature = 1'b0, q, fr = 1'b1;
  logic [NPIN-1:0] i_core_output_to_cell = 2'b10, i_core_oe_to_cell = 2'b11;
  logic [NPIN-1:0] i_pin_in = 2'b01, o_pin_out, o_pin_oe;
  logic o_snap_valid, i_snap_ready, fv;
  logic [3*NPIN-1:0] o_snap_data, fd;
  logic [9:0] o_ir, cur = `BST_OP_IDCODE;
  logic [15:0] cap;
  int err_total = 0, checks = 0;
  bst_tester i_bst_tester (.i_clk_sys, .o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi),
    .i_tdo(o_tdo), .i_tdo_oe_n(o_tdo_oe_n));
  bst_tap #(.NPIN(NPIN)) i_bst_tap (.*);
  bst_fifo #(.WIDTH(3*NPIN), .DEPTH(8), .AW(3)) i_bst_fifo (.i_clk_sys, .i_rst_n,
    .i_in_valid(o_snap_valid), .o_in_ready(i_snap_ready), .i_in_data(o_snap_data),
    .o_out_valid(fv), .i_out_ready(fr), .o_out_data(fd));
  always #50 i_clk_sys = ~i_clk_sys;
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task test_done;
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic scan(input logic irs, input int n, input logic [15:0] din,
                      output logic [15:0] dout);
    i_bst_tester.step(1'b1, 1'b1, q);
    if (irs) i_bst_tester.step(1'b1, 1'b1, q);
    i_bst_tester.step(1'b0, 1'b1, q);
    i_bst_tester.step(1'b0, 1'b1, q);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      dout[i] = q;
      // last bit leaves with TMS high
      i_bst_tester.step(i == n - 1, din[i], q);
    end
    chk("tdo_off", q, 1'bz);
    i_bst_tester.step(1'b1, 1'b1, q);
    i_bst_tester.step(1'b0, 1'b1, q);
  endtask
  task automatic ld(input logic [9:0] code);
    logic [15:0] d;
    scan(1'b1, 10, code, d);
    chk("ir_out", d, cur);
    chk("ir", o_ir, code);
    cur = code;
  endtask
  task automatic t_codes;
    logic [9:0] ops [7] = '{`BST_OP_SAMPLE, `BST_OP_EXTEST, `BST_OP_USERCODE,
      `BST_OP_CLAMP, `BST_OP_HIGHZ, `BST_OP_IDCODE, `BST_OP_BYPASS};
    foreach (ops[i]) ld(ops[i]);
  endtask
  task automatic t_bypass;
    logic [15:0] d;
    for (int k = 0; k < 2; k++) begin
      if (k == 1) ld(10'h155);
      scan(1'b0, 5, 16'h0016, d);
      chk("bypass", d, (16'h0016 << 1) & 16'h001F);
    end
  endtask
  task automatic t_sample;
    logic [15:0] d, din = 16'h0AE5;
    cap = '0;
    for (int k = 0; k < NPIN; k++) begin
      cap[3*k] = i_core_output_to_cell[k];
      cap[3*k+1] = i_core_oe_to_cell[k];
      cap[3*k+2] = i_pin_in[k];
    end
    i_goe_feature = 1'b1;
    fr = 1'b0;
    ld(`BST_OP_SAMPLE);
    chk("pin_out", o_pin_out, i_core_output_to_cell);
    chk("pin_oe", o_pin_oe, 0);
    scan(1'b0, 6*NPIN, din, d);
    chk("chain", d, {din[3*NPIN-1:0], cap[3*NPIN-1:0]});
    chk("snap", fd, cap);
    i_goe_feature = 1'b0;
    ld(`BST_OP_EXTEST);
    for (int k = 0; k < NPIN; k++) begin
      chk("upd_out", o_pin_out[k], din[3*NPIN+3*k]);
      chk("upd_oe", o_pin_oe[k], din[3*NPIN+3*k+1]);
    end
    ld(`BST_OP_CLAMP);
    chk("clamp", {o_pin_oe, o_pin_out}, {din[10], din[7], din[9], din[6]});
  endtask
  task automatic t_ident;
    logic [15:0] d;
    logic [31:0] id = `BST_ID_RST, uc = `BST_UC_RST;
    ld(`BST_OP_IDCODE);
    scan(1'b0, 16, 16'h0000, d);
    chk("idcode", d, id[15:0]);
    ld(`BST_OP_USERCODE);
    scan(1'b0, 16, 16'h0000, d);
    chk("usercode", d, uc[15:0]);
  endtask
  // Captures pile up while the drain side stalls
  task automatic t_fifo;
    logic [4:0] seq = 5'b01101;
    int n = 0;
    ld(`BST_OP_SAMPLE);
    repeat (9) for (int j = 0; j < 5; j++) i_bst_tester.step(seq[j], 1'b1, q);
    chk("full", i_snap_ready, 1'b0);
    fr = 1'b1;
    repeat (30) begin
      if (fv === 1'b1) begin
        n++;
        chk("drain", fd, cap);
      end
      @(negedge i_clk_sys);
    end
    chk("count", 16'(n), 16'd9);
    chk("empty", fv, 1'b0);
  endtask
  task automatic t_tmsrst;
    i_bst_tester.step(1'b1, 1'b1, q);
    i_bst_tester.step(1'b0, 1'b1, q);
    i_bst_tester.step(1'b0, 1'b1, q);
    chk("oe_on", q === 1'bz, 1'b0);
    // five highs reach reset, more keep it there
    repeat (7) i_bst_tester.step(1'b1, 1'b1, q);
    chk("ir_rst", o_ir, `BST_OP_IDCODE);
    chk("oe_off", q, 1'bz);
  endtask
  initial begin
    repeat (4) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    chk("ir_init", o_ir, `BST_OP_IDCODE);
    chk("oe_init", o_tdo_oe_n, 1'b1);
    repeat (2) @(negedge i_clk_sys);
    // leading 0, then 1100 inside each instruction scan, 100 inside each data scan
    i_bst_tester.step(1'b0, 1'b1, q);
    t_codes;
    t_bypass;
    t_sample;
    t_ident;
    t_fifo;
    t_tmsrst;
    test_done;
  end
endmodule
